// [power_down_and_balance_timers.sv]
// Power-down delay timer and six cell-balance gate timers.
// Assumes register writes and reads arrive as one-cycle strobes from the
// serial interface logic, and that the shutdown pin is synchronous.
`timescale 1ns/10ps
module power_down_and_balance_timers
   import batt_timer_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES,
   parameter int unsigned FILTER_LEN = FILTER_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Shutdown pin from the host
   input wire logic shutdown_request_n,
   // Register access
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [3:0] reg_select,
   input wire logic [WDATA_W-1:0] reg_wdata,
   output logic [WDATA_W-1:0] reg_rdata,
   // Cell-balance gates
   output logic [NUM_GATES-1:0] balance_gate_out,
   // Power state
   output logic full_shutdown,
   output logic soft_shutdown,
   output logic shutdown_timer_running
);

   ////////////////////////////////////////////////////////////////////////
   // Tick and pin filter

   logic tick;
   logic pin_high;
   logic pin_high_q;

   tick_divider #(.CYCLES(TICK_LEN)) u_tick (
      .clock(clock),
      .reset(reset),
      .tick(tick)
   );

   level_filter #(.CYCLES(FILTER_LEN)) u_filter (
      .clock(clock),
      .reset(reset),
      .raw(shutdown_request_n),
      .level(pin_high)
   );

   // Previous filtered level for edge detection
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pin_high_q <= 1'b1;
      end else begin
         pin_high_q <= pin_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write decode

   logic pin_fall;
   logic pin_rise;
   logic wr_control;
   logic wr_delay;
   logic wr_balance;
   logic wr_timer;
   logic soft_set;
   logic [2:0] timer_idx;
   logic [STEP_W-1:0] new_steps;
   logic [NUM_GATES-1:0] new_gates;

   assign pin_fall = pin_high_q && !pin_high;
   assign pin_rise = !pin_high_q && pin_high;
   assign wr_control = reg_write && (reg_select == SEL_CONTROL);
   assign wr_delay = reg_write && (reg_select == SEL_SHUTDOWN_DELAY);
   assign wr_balance = reg_write && (reg_select == SEL_BALANCE);
   assign wr_timer = reg_write && (reg_select >= SEL_TIMER_FIRST)
      && (reg_select <= SEL_TIMER_LAST);
   assign soft_set = wr_control && reg_wdata[SOFT_PD_BIT];
   assign timer_idx = 3'(reg_select - SEL_TIMER_FIRST);
   assign new_steps = step_field(reg_wdata);
   assign new_gates = reg_wdata[GATE_LSB +: NUM_GATES];

   ////////////////////////////////////////////////////////////////////////
   // Timer value registers

   logic [STEP_W-1:0] delay_steps_q;
   logic [STEP_W-1:0] timer_steps_q [NUM_GATES];
   logic ctrl_soft_q;

   // Delay and balance timer values, reset to zero
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         delay_steps_q <= STEP_RESET;
         for (int i = 0; i < NUM_GATES; i++) begin
            timer_steps_q[i] <= STEP_RESET;
         end
      end else begin
         if (wr_delay) begin
            delay_steps_q <= new_steps;
         end
         if (wr_timer) begin
            timer_steps_q[timer_idx] <= new_steps;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shutdown sequencer

   pd_state_e pd_state_q;
   logic [COUNT_W-1:0] pd_count_q;
   logic [COUNT_W-1:0] pd_count_next;
   logic pd_expire;
   logic enter_down;

   assign pd_count_next = pd_count_q + COUNT_W'(1);
   // Expiry on matching tick, or at once when the delay is rewritten to zero
   assign pd_expire = (pd_state_q == PD_DELAY) && (wr_delay ? (new_steps == STEP_RESET)
      : (tick && pd_count_next == step_ticks(delay_steps_q)));
   assign enter_down = ((pd_state_q == PD_RUN) && pin_fall && delay_steps_q == STEP_RESET)
      || (pd_expire && !pin_high);

   // Sequencer state, delay count and power outputs
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pd_state_q <= PD_RUN;
         pd_count_q <= COUNT_ZERO;
         full_shutdown <= 1'b0;
         shutdown_timer_running <= 1'b0;
      end else begin
         unique case (pd_state_q)
            PD_RUN: begin
               if (enter_down) begin
                  pd_state_q <= PD_DOWN;
                  full_shutdown <= 1'b1;
               end else if ((pin_fall || soft_set) && delay_steps_q != STEP_RESET) begin
                  pd_state_q <= PD_DELAY;
                  pd_count_q <= COUNT_ZERO;
                  shutdown_timer_running <= 1'b1;
               end
            end
            PD_DELAY: begin
               // A pin rise is ignored here on purpose
               if (pd_expire) begin
                  pd_state_q <= pin_high ? PD_RUN : PD_DOWN;
                  full_shutdown <= !pin_high;
                  pd_count_q <= COUNT_ZERO;
                  shutdown_timer_running <= 1'b0;
               end else if (wr_delay) begin
                  pd_count_q <= COUNT_ZERO;
               end else if (tick) begin
                  pd_count_q <= pd_count_next;
               end
            end
            PD_DOWN: begin
               if (pin_high) begin
                  pd_state_q <= PD_RUN;
                  full_shutdown <= 1'b0;
               end
            end
         endcase
      end
   end

   // Soft power-down bit; takes effect at once only with zero delay
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_soft_q <= 1'b0;
         soft_shutdown <= 1'b0;
      end else if (wr_control) begin
         ctrl_soft_q <= reg_wdata[SOFT_PD_BIT];
         if (!reg_wdata[SOFT_PD_BIT]) begin
            soft_shutdown <= 1'b0;
         end else if (delay_steps_q == STEP_RESET && pd_state_q == PD_RUN) begin
            soft_shutdown <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cell-balance gates and shared counter

   logic bal_active_q;
   logic [COUNT_W-1:0] bal_count_q;
   logic [COUNT_W-1:0] bal_count_next;
   logic [NUM_GATES-1:0] timed_mask;
   logic [NUM_GATES-1:0] hit;
   logic [NUM_GATES-1:0] remaining;

   assign bal_count_next = bal_count_q + COUNT_W'(1);

   // Which gates carry a timer and which expire on this tick
   always_comb begin
      timed_mask = '0;
      hit = '0;
      for (int i = 0; i < NUM_GATES; i++) begin
         timed_mask[i] = timer_steps_q[i] != STEP_RESET;
         hit[i] = tick && bal_active_q && balance_gate_out[i] && timed_mask[i]
            && (bal_count_next == step_ticks(timer_steps_q[i]));
      end
      remaining = balance_gate_out & timed_mask & ~hit;
   end

   // Gate register, counter activation and expiry
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         balance_gate_out <= GATE_RESET;
         bal_active_q <= 1'b0;
         bal_count_q <= COUNT_ZERO;
      end else if (enter_down) begin
         balance_gate_out <= GATE_RESET;
         bal_active_q <= 1'b0;
         bal_count_q <= COUNT_ZERO;
      end else if (wr_balance) begin
         balance_gate_out <= new_gates;
         if ((new_gates & timed_mask) == GATE_RESET) begin
            bal_active_q <= 1'b0;
            bal_count_q <= COUNT_ZERO;
         end else if (!bal_active_q) begin
            bal_active_q <= 1'b1;
            bal_count_q <= COUNT_ZERO;
         end else if (tick) begin
            bal_count_q <= bal_count_next;
         end
      end else if (wr_timer && balance_gate_out[timer_idx]) begin
         bal_active_q <= 1'b1;
         bal_count_q <= COUNT_ZERO;
         if (new_steps == STEP_RESET) begin
            balance_gate_out[timer_idx] <= 1'b0;
         end
      end else if (tick && bal_active_q) begin
         // Write to a dark gate's timer falls through to here
         balance_gate_out <= balance_gate_out & ~hit;
         if (remaining == GATE_RESET) begin
            bal_active_q <= 1'b0;
            bal_count_q <= COUNT_ZERO;
         end else begin
            bal_count_q <= bal_count_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read back

   // Registered read data, zero for unmapped selects
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         reg_rdata <= '0;
         if (reg_select == SEL_CONTROL) begin
            reg_rdata[SOFT_PD_BIT] <= ctrl_soft_q;
         end else if (reg_select == SEL_SHUTDOWN_DELAY) begin
            reg_rdata[TIMER_LSB +: STEP_W] <= delay_steps_q;
         end else if (reg_select == SEL_BALANCE) begin
            reg_rdata[GATE_LSB +: NUM_GATES] <= balance_gate_out;
         end else if (reg_select >= SEL_TIMER_FIRST && reg_select <= SEL_TIMER_LAST) begin
            reg_rdata[TIMER_LSB +: STEP_W] <= timer_steps_q[timer_idx];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_soft_immediate: assert property (
      soft_set && delay_steps_q == STEP_RESET && pd_state_q == PD_RUN |=> soft_shutdown)
      else $error("soft power-down not taken");
   chk_delay_start: assert property (
      pd_state_q == PD_RUN && pin_fall && delay_steps_q != STEP_RESET
      |=> pd_state_q == PD_DELAY && shutdown_timer_running && pd_count_q == COUNT_ZERO)
      else $error("delay timer did not start");
   chk_expire_low: assert property (
      pd_expire && !pin_high |=> full_shutdown && balance_gate_out == GATE_RESET)
      else $error("no power-down on expiry with pin low");
   chk_expire_high: assert property (
      pd_expire && pin_high |=> !full_shutdown && pd_state_q == PD_RUN)
      else $error("power-down on expiry with pin high");
   chk_delay_rewrite: assert property (
      pd_state_q == PD_DELAY && wr_delay && new_steps != STEP_RESET
      |=> pd_state_q == PD_DELAY && pd_count_q == COUNT_ZERO)
      else $error("delay rewrite did not restart");
   chk_rise_keeps: assert property (
      pd_state_q == PD_DELAY && pin_rise && !pd_expire |=> pd_state_q == PD_DELAY)
      else $error("pin rise cancelled delay");
   chk_zero_delay_down: assert property (
      pd_state_q == PD_RUN && pin_fall && delay_steps_q == STEP_RESET
      |=> full_shutdown && pd_state_q == PD_DOWN
      && balance_gate_out == GATE_RESET)
      else $error("zero delay fall did not power down");
   chk_gates_follow: assert property (
      wr_balance && !enter_down |=> balance_gate_out == $past(new_gates))
      else $error("gates do not follow balance write");
   chk_lit_timer_write: assert property (
      wr_timer && balance_gate_out[timer_idx] && !enter_down && !wr_balance
      |=> bal_count_q == COUNT_ZERO && bal_active_q)
      else $error("lit timer write did not restart counter");
   chk_idle_counter: assert property (
      !bal_active_q |-> bal_count_q == COUNT_ZERO)
      else $error("counter not cleared while idle");
   chk_filter_hold: assert property (
      $fell(pin_high) |-> $past(shutdown_request_n, 2) == 1'b0)
      else $error("filter passed an unheld low");

   // Timer bookkeeping and power-state checks
   chk_dark_timer_write: assert property (
      wr_timer && !balance_gate_out[timer_idx] && !tick && !enter_down
      |=> bal_count_q == $past(bal_count_q))
      else $error("dark timer write moved counter");
   chk_gate_expiry: assert property (
      hit != GATE_RESET && !enter_down && !wr_balance && !wr_timer
      |=> (balance_gate_out & $past(hit)) == GATE_RESET)
      else $error("expired gate still on");
   chk_idle_stays: assert property (
      !bal_active_q && !wr_balance && !wr_timer |=> !bal_active_q)
      else $error("counter started without a write");
   chk_tick_pulse: assert property (
      tick |=> !tick)
      else $error("tick longer than one cycle");
   chk_running_flag: assert property (
      shutdown_timer_running == (pd_state_q == PD_DELAY))
      else $error("running flag disagrees with sequencer");
   chk_soft_clear: assert property (
      wr_control && !reg_wdata[SOFT_PD_BIT] |=> !soft_shutdown)
      else $error("soft power-down not cleared");
   chk_delay_idle: assert property (
      pd_state_q != PD_DELAY |-> pd_count_q == COUNT_ZERO)
      else $error("delay count not zero while idle");
   chk_down_holds: assert property (
      pd_state_q == PD_DOWN && !pin_high |=> full_shutdown && pd_state_q == PD_DOWN)
      else $error("left power-down with pin low");

   cov_delay_down: cover property (pd_state_q == PD_DELAY ##1 pd_state_q == PD_DOWN);
   cov_delay_rewrite: cover property (pd_state_q == PD_DELAY && wr_delay);
   cov_gate_expiry: cover property (tick && hit != GATE_RESET);
   cov_zero_down: cover property (pd_state_q == PD_RUN ##1 pd_state_q == PD_DOWN);
   cov_all_done: cover property (bal_active_q ##1 !bal_active_q && tick);

endmodule

// [batt_timer_pkg.sv]
// Constants, register selects and helper functions for the power-down
// and cell-balance timer block.
// Assumes a 100 MHz clock and a 16-bit register write path.
package batt_timer_pkg;

   // Clock and timing
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int CLOCK_HZ = 100_000_000;
   localparam int TICK_TIME_MS = 4500;
   localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_TIME_MS;
   localparam int FILTER_TIME_NS = 130_000;
   localparam int FILTER_CYCLES = FILTER_TIME_NS / CLOCK_PERIOD_NS;
   localparam int TICKS_PER_STEP_LOG2 = 4;

   // Register field layout
   localparam int STEP_W = 5;
   localparam int TIMER_LSB = 3;
   localparam int GATE_LSB = 2;
   localparam int NUM_GATES = 6;
   localparam int SOFT_PD_BIT = 8;
   localparam int COUNT_W = STEP_W + TICKS_PER_STEP_LOG2;
   localparam int WDATA_W = 16;

   // Reset values
   localparam logic [STEP_W-1:0] STEP_RESET = 5'h00;
   localparam logic [NUM_GATES-1:0] GATE_RESET = 6'h00;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 9'h000;

   // Register selects
   localparam logic [3:0] SEL_CONTROL = 4'h0;
   localparam logic [3:0] SEL_SHUTDOWN_DELAY = 4'h1;
   localparam logic [3:0] SEL_BALANCE = 4'h2;
   localparam logic [3:0] SEL_TIMER_FIRST = 4'h3;
   localparam logic [3:0] SEL_TIMER_LAST = 4'h8;

   // Shutdown sequencer, codes one bit apart except RUN and DOWN
   typedef enum logic [1:0] {
      PD_RUN = 2'h0,
      PD_DELAY = 2'h1,
      PD_DOWN = 2'h3
   } pd_state_e;

   // Step count to tick count
   function automatic logic [COUNT_W-1:0] step_ticks(input logic [STEP_W-1:0] steps);
      step_ticks = {steps, {TICKS_PER_STEP_LOG2{1'b0}}};
   endfunction

   // Step field of a timer write
   function automatic logic [STEP_W-1:0] step_field(input logic [WDATA_W-1:0] wdata);
      step_field = wdata[TIMER_LSB +: STEP_W];
   endfunction

endpackage

// [tick_divider.sv]
// Free-running prescaler giving a one-cycle tick pulse.
// Assumes a single clock; CYCLES is at least two.
`timescale 1ns/10ps
module tick_divider
   import batt_timer_pkg::*;
#(
   parameter int unsigned CYCLES = TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Tick out
   output logic tick
);

   logic [31:0] div_q;

   // Cycle counter and tick pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_q <= 32'h0;
         tick <= 1'b0;
      end else if (div_q == CYCLES - 1) begin
         div_q <= 32'h0;
         tick <= 1'b1;
      end else begin
         div_q <= div_q + 32'h1;
         tick <= 1'b0;
      end
   end

endmodule

// [level_filter.sv]
// Deglitch filter: the output follows the input only after the input
// has held its new level for CYCLES clocks.
// Assumes the input is synchronous to the clock; idles high.
`timescale 1ns/10ps
module level_filter
   import batt_timer_pkg::*;
#(
   parameter int unsigned CYCLES = FILTER_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Raw and filtered level
   input wire logic raw,
   output logic level
);

   logic [15:0] hold_q;

   // Count while input differs, flip when held long enough
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         hold_q <= 16'h0;
         level <= 1'b1;
      end else if (raw == level) begin
         hold_q <= 16'h0;
      end else if (hold_q == 16'(CYCLES - 1)) begin
         hold_q <= 16'h0;
         level <= raw;
      end else begin
         hold_q <= hold_q + 16'h1;
      end
   end

endmodule

// [host_side_model.sv]
// Host side of the timer block: shutdown pin and register strobes.
// Assumes the block samples on the rising edge; we drive at falling.
`timescale 1ns/10ps
module host_side_model
   import batt_timer_pkg::*;
#(
   parameter int HW_WAKE = 20,
   parameter int SW_WAKE = 10
) (
   // Clock
   input wire logic clock,
   // Pin and register access
   output logic shutdown_request_n,
   output logic reg_write,
   output logic reg_read,
   output logic [3:0] reg_select,
   output logic [WDATA_W-1:0] reg_wdata,
   input wire logic [WDATA_W-1:0] reg_rdata
);
   ////////////////////////////////////////////////////////////////////
   // Idle levels at time zero
   initial begin
      shutdown_request_n = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_select = 4'h0;
      reg_wdata = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////
   // Bus cycles
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic wr(input logic [3:0] s, input logic [WDATA_W-1:0] d);
      @(negedge clock);
      reg_select = s;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
      reg_wdata = ~d; // Released data shows no stale value
   endtask

   task automatic rd(input logic [3:0] s, output logic [WDATA_W-1:0] d);
      @(negedge clock);
      reg_select = s;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask

   task automatic pin(input logic v);
      @(negedge clock);
      shutdown_request_n = v;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Power sequences; this host never starts a conversion
   task automatic soft_down();
      wr(SEL_CONTROL, 16'h0100);
   endtask

   // Recovery waits, scaled down
   task automatic soft_wake();
      wr(SEL_CONTROL, 16'h0000);
      idle(SW_WAKE);
   endtask

   task automatic hw_wake();
      pin(1'b1);
      idle(HW_WAKE);
   endtask
endmodule

// [tb.sv]
// Self-checking bench for the power-down and balance timer block.
// Assumes short tick and filter lengths so one step is 320 cycles.
`timescale 1ns/10ps
module tb
   import batt_timer_pkg::*;
;
   localparam int TL = 20;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic shutdown_request_n, reg_write, reg_read;
   logic [3:0] reg_select;
   logic [15:0] reg_wdata, reg_rdata;
   logic [5:0] balance_gate_out;
   logic full_shutdown, soft_shutdown, shutdown_timer_running;
   int n_errors = 0;
   int check_count = 0;
   logic [31:0] rnd = 32'h0eeaee20;

   ////////////////////////////////////////////////////////////////////
   // Clock, design and host
   always #5 clock = ~clock;

   power_down_and_balance_timers #(.TICK_LEN(TL), .FILTER_LEN(8))
   u_power_down_and_balance_timers (
      .clock(clock), .reset(reset), .shutdown_request_n(shutdown_request_n),
      .reg_write(reg_write), .reg_read(reg_read), .reg_select(reg_select),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .balance_gate_out(balance_gate_out), .full_shutdown(full_shutdown),
      .soft_shutdown(soft_shutdown),
      .shutdown_timer_running(shutdown_timer_running));

   host_side_model u_host_side_model (
      .clock(clock), .shutdown_request_n(shutdown_request_n),
      .reg_write(reg_write), .reg_read(reg_read), .reg_select(reg_select),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   ////////////////////////////////////////////////////////////////////
   // Expectations and helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] stp(input int n);
      return 16'(n) << 3;
   endfunction
   function automatic logic [15:0] gw(input logic [5:0] g);
      return {8'h00, g, 2'b00};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string w);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, w, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] s, input logic [15:0] d);
      u_host_side_model.wr(s, d);
   endtask
   task automatic idle(input int n);
      u_host_side_model.idle(n);
   endtask
   task automatic pin(input logic v);
      u_host_side_model.pin(v);
   endtask
   task automatic rdchk(input logic [3:0] s, input logic [15:0] e);
      logic [15:0] d;
      u_host_side_model.rd(s, d);
      check(d, e, "read");
   endtask
   task automatic gchk(input logic [5:0] e);
      check({10'h000, balance_gate_out}, {10'h000, e}, "gates");
   endtask
   task automatic pchk(input logic f, input logic s, input logic r);
      check({13'h0000, full_shutdown, soft_shutdown, shutdown_timer_running},
            {13'h0000, f, s, r}, "power");
   endtask
   // Gate state just before and just after a one step expiry
   task automatic expire(input logic [5:0] b, input logic [5:0] a);
      idle(288);
      gchk(b);
      idle(40);
      gchk(a);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (30000) @(posedge clock);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      conclude();
   end

   ////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (16) @(negedge clock);
      reset = 1'b0;
      gchk(6'h00);
      pchk(1'b0, 1'b0, 1'b0);
      for (int s = 0; s < 10; s++) rdchk(4'(s), 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         wr(SEL_BALANCE, rnd[15:0]);
         gchk(rnd[7:2]);
         rdchk(SEL_BALANCE, gw(rnd[7:2]));
      end
      wr(SEL_BALANCE, 16'h0000);
      wr(4'hf, 16'hffff);
      gchk(6'h00);
      $display("test gate map done");
      wr(SEL_TIMER_FIRST, stp(1));
      wr(SEL_TIMER_FIRST + 4'h1, stp(3));
      gchk(6'h00);
      wr(SEL_BALANCE, gw(6'h03));
      expire(6'h03, 6'h02);
      rdchk(SEL_TIMER_FIRST, stp(1));
      rdchk(SEL_BALANCE, gw(6'h02));
      idle(650);
      gchk(6'h00);
      rdchk(SEL_TIMER_FIRST + 4'h1, stp(3));
      wr(SEL_BALANCE, gw(6'h11));
      expire(6'h11, 6'h10);
      wr(SEL_BALANCE, 16'h0000);
      $display("test balance expiry done");
      wr(SEL_TIMER_FIRST + 4'h2, stp(1));
      wr(SEL_BALANCE, gw(6'h04));
      idle(150);
      wr(SEL_TIMER_FIRST + 4'h3, stp(2));
      idle(135);
      gchk(6'h04);
      idle(40);
      gchk(6'h00);
      wr(SEL_BALANCE, gw(6'h04));
      idle(150);
      wr(SEL_TIMER_FIRST + 4'h2, stp(1));
      expire(6'h04, 6'h00);
      wr(SEL_BALANCE, gw(6'h04));
      idle(10);
      wr(SEL_TIMER_FIRST + 4'h2, 16'h0000);
      gchk(6'h00);
      wr(SEL_TIMER_FIRST + 4'h2, stp(1));
      wr(SEL_BALANCE, gw(6'h04));
      idle(20);
      wr(SEL_BALANCE, 16'h0000);
      gchk(6'h00);
      $display("test timer rewrite done");
      wr(SEL_BALANCE, gw(6'h30));
      pin(1'b0);
      idle(4);
      pin(1'b1);
      idle(20);
      pchk(1'b0, 1'b0, 1'b0);
      pin(1'b0);
      idle(12);
      pchk(1'b1, 1'b0, 1'b0);
      gchk(6'h00);
      u_host_side_model.hw_wake();
      pchk(1'b0, 1'b0, 1'b0);
      wr(SEL_SHUTDOWN_DELAY, stp(1));
      wr(SEL_BALANCE, gw(6'h30));
      pin(1'b0);
      idle(12);
      pchk(1'b0, 1'b0, 1'b1);
      pin(1'b1);
      idle(280);
      pchk(1'b0, 1'b0, 1'b1);
      idle(50);
      pchk(1'b0, 1'b0, 1'b0);
      pin(1'b0);
      idle(12);
      gchk(6'h30);
      idle(330);
      pchk(1'b1, 1'b0, 1'b0);
      gchk(6'h00);
      u_host_side_model.hw_wake();
      pin(1'b0);
      idle(150);
      wr(SEL_SHUTDOWN_DELAY, stp(1));
      idle(290);
      pchk(1'b0, 1'b0, 1'b1);
      idle(40);
      pchk(1'b1, 1'b0, 1'b0);
      u_host_side_model.hw_wake();
      wr(SEL_SHUTDOWN_DELAY, stp(2));
      pin(1'b0);
      idle(20);
      wr(SEL_SHUTDOWN_DELAY, 16'h0000);
      idle(2);
      pchk(1'b1, 1'b0, 1'b0);
      u_host_side_model.hw_wake();
      $display("test delay timer done");
      u_host_side_model.soft_down();
      idle(2);
      pchk(1'b0, 1'b1, 1'b0);
      u_host_side_model.soft_wake();
      pchk(1'b0, 1'b0, 1'b0);
      wr(SEL_SHUTDOWN_DELAY, stp(1));
      u_host_side_model.soft_down();
      idle(2);
      pchk(1'b0, 1'b0, 1'b1);
      idle(340);
      pchk(1'b0, 1'b0, 1'b0);
      u_host_side_model.soft_wake();
      $display("test soft power-down done");
      conclude();
   end
endmodule
